// ==== core/adc_rate_pkg.sv ====
// Constants, types and helpers for the converter rate and sleep controller
//
// How it works
// - Oversample ratio spans 64 up to 32768
// - Notch at sample rate over ratio
// - Pin grounded: internal 1.8MHz modulator clock
// - Results arrive at one eighth notch rate
// - External clock on pin divided by five
// - Ratio changes filter only, not sample rate
// - Ten power-of-two ratio steps
// - Config input high forces ratio 32768
// - Ratio 64 conversion takes about 0.285ms
// - Sleep entered automatically after each conversion
// - Sleep holds while chip select high, idle
// - Busy and done_n high converting, low asleep
package adc_rate_pkg;

    // ========================================
    // Clocking
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int INT_OSC_HZ = 1_800_000;
    localparam int PHASE_W = 26;
    localparam logic [PHASE_W-1:0] PHASE_MOD = PHASE_W'(CLK_HZ);
    localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(INT_OSC_HZ);
    localparam int EXT_DIV = 5;
    localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
    localparam int EXT_TIMEOUT_NS = 20_000;
    localparam int EXT_TIMEOUT_CYC = EXT_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int TMO_W = 12;

    // ========================================
    // Filter
    localparam int CODE_W = 4;
    localparam logic [CODE_W-1:0] CODE_MAX = 4'h9;
    localparam int OSR_MIN_LOG2 = 6;
    localparam int OUT_DIV_LOG2 = 3;
    localparam int CNT_W = 19;
    localparam int SUM_W = 16;
    localparam int RESULT_W = 24;
    localparam int FULL_SCALE_LOG2 = 23;
    localparam int STAT_W = 16;

    // ========================================
    // Register map (byte addresses)
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] REG_RESULT = 5'h08;
    localparam logic [ADDR_W-1:0] REG_RATIO = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_COUNT = 5'h10;
    localparam logic [CODE_W-1:0] CTRL_RESET = 4'h0;

    typedef enum logic [1:0]
    {
        ST_CONVERT = 2'b00,
        ST_SLEEP = 2'b01,
        ST_READOUT = 2'b10
    } conv_state_t;

    // Ratio for a step code
    function automatic logic [CNT_W-1:0] osr_of(input logic [CODE_W-1:0] code);
        osr_of = CNT_W'(1) << (OSR_MIN_LOG2 + 32'(code));
    endfunction : osr_of

    // Left shift that brings a window sum to full scale
    function automatic logic [4:0] scale_shift(input logic [CODE_W-1:0] code);
        scale_shift = 5'(FULL_SCALE_LOG2 - OSR_MIN_LOG2) - 5'(code);
    endfunction : scale_shift

endpackage : adc_rate_pkg

// ==== core/osc_source_detect.sv ====
// Detects whether an external clock is toggling the oscillator select pin
`timescale 1ns/1ps
`default_nettype none
module osc_source_detect #(
    parameter int TIMEOUT_CYC = adc_rate_pkg::EXT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin
    input wire logic osc_source_pin,
    // Result
    output logic ext_active,
    output logic ext_rise
);
    logic pin_r;
    logic [adc_rate_pkg::TMO_W-1:0] tmo_r;
    logic active_r;

    assign ext_rise = osc_source_pin & ~pin_r;
    assign ext_active = active_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_r <= 1'b0;
        else
            pin_r <= osc_source_pin;
    end

    // A pin held low or high has no edges and falls back to the oscillator
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmo_r <= '0;
            active_r <= 1'b0;
        end
        else if (ext_rise)
        begin
            tmo_r <= adc_rate_pkg::TMO_W'(TIMEOUT_CYC);
            active_r <= 1'b1;
        end
        else if (tmo_r != '0)
            tmo_r <= tmo_r - 1'b1;
        else
            active_r <= 1'b0;
    end
endmodule : osc_source_detect
`default_nettype wire

// ==== core/sample_tick_gen.sv ====
// Modulator sample strobe from the internal oscillator or the external clock
`timescale 1ns/1ps
`default_nettype none
module sample_tick_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Source
    input wire logic ext_active,
    input wire logic ext_rise,
    // Strobe
    output logic sample_tick
);
    logic [adc_rate_pkg::PHASE_W-1:0] phase_r;
    logic [adc_rate_pkg::PHASE_W-1:0] phase_sum;
    logic [2:0] div_r;
    logic int_tick;

    assign phase_sum = phase_r + adc_rate_pkg::PHASE_STEP;
    assign int_tick = phase_sum >= adc_rate_pkg::PHASE_MOD;
    assign sample_tick = ext_active
        ? (ext_rise && div_r == adc_rate_pkg::EXT_DIV_LAST)
        : int_tick;

    // Fractional divider gives 1.8MHz on average from 40MHz
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_r <= '0;
        else if (int_tick)
            phase_r <= phase_sum - adc_rate_pkg::PHASE_MOD;
        else
            phase_r <= phase_sum;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= '0;
        else if (!ext_active)
            div_r <= '0;
        else if (ext_rise)
            div_r <= (div_r == adc_rate_pkg::EXT_DIV_LAST) ? 3'h0 : div_r + 3'h1;
    end
endmodule : sample_tick_gen
`default_nettype wire

// ==== core/adc_rate_sleep_ctrl.sv ====
// Conversion timing, decimation and autosleep control with Avalon-MM registers
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module adc_rate_sleep_ctrl #(
    parameter int EXT_TIMEOUT_CYC = adc_rate_pkg::EXT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [adc_rate_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Converter pins and modulator
    input wire logic osc_source_pin,
    input wire logic serial_config_in,
    input wire logic cs_n,
    input wire logic mod_bit,
    // Readout engine
    input wire logic shift_active,
    input wire logic readout_done,
    // Status and data
    output logic busy,
    output logic conv_done_n,
    output logic [adc_rate_pkg::RESULT_W-1:0] result,
    output logic ext_clock_active
);

    // ========================================
    // Sample clock source
    logic ext_active;
    logic ext_rise;
    logic sample_tick;

    osc_source_detect #(
        .TIMEOUT_CYC(EXT_TIMEOUT_CYC)
    ) u_detect (
        .clk(clk),
        .rst_n(rst_n),
        .osc_source_pin(osc_source_pin),
        .ext_active(ext_active),
        .ext_rise(ext_rise)
    );

    // One strobe source for every ratio keeps the sample rate fixed
    sample_tick_gen u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .ext_active(ext_active),
        .ext_rise(ext_rise),
        .sample_tick(sample_tick)
    );

    assign ext_clock_active = ext_active;

    // ========================================
    // State and registers
    adc_rate_pkg::conv_state_t state_r;
    adc_rate_pkg::conv_state_t state_nxt;
    logic [adc_rate_pkg::CODE_W-1:0] ctrl_code_r;
    logic [adc_rate_pkg::CODE_W-1:0] act_code_r;
    logic [adc_rate_pkg::CODE_W-1:0] sel_code;
    logic [adc_rate_pkg::CNT_W-1:0] sample_cnt_r;
    logic [adc_rate_pkg::CNT_W-1:0] oversample_ratio;
    logic [adc_rate_pkg::CNT_W-1:0] conv_last;
    logic [adc_rate_pkg::SUM_W-1:0] sum_r;
    logic [adc_rate_pkg::SUM_W-1:0] sum_in;
    logic [adc_rate_pkg::RESULT_W-1:0] result_r;
    logic [adc_rate_pkg::STAT_W-1:0] conv_count_r;
    logic window_start;
    logic conv_end;
    logic busy_r;
    logic ack_r;
    logic [31:0] readdata_r;
    logic [31:0] rd_mux;

    // ========================================
    // Ratio selection
    // Config pin high overrides the programmed step
    assign sel_code = serial_config_in ? adc_rate_pkg::CODE_MAX : ctrl_code_r;

    // The ratio is frozen for the whole conversion, so a mid-conversion
    // write only affects the next one
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            act_code_r <= adc_rate_pkg::CTRL_RESET;
        else if (state_r != adc_rate_pkg::ST_CONVERT)
            act_code_r <= sel_code;
    end

    assign oversample_ratio = adc_rate_pkg::osr_of(act_code_r);

    // Eight filter windows per result: output rate is notch over eight
    assign conv_last = (oversample_ratio << adc_rate_pkg::OUT_DIV_LOG2) - 1'b1;
    // At ratio 64 and 1.8MHz this is 512 samples, about 0.285ms
    assign conv_end = sample_tick && sample_cnt_r == conv_last;

    // ========================================
    // Decimation filter
    // Window of length ratio: boxcar with nulls at rate/ratio and multiples
    assign window_start = (sample_cnt_r & (oversample_ratio - 1'b1)) == '0;
    assign sum_in = window_start ? adc_rate_pkg::SUM_W'(mod_bit)
                                 : sum_r + adc_rate_pkg::SUM_W'(mod_bit);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sample_cnt_r <= '0;
        else if (state_r != adc_rate_pkg::ST_CONVERT)
            sample_cnt_r <= '0;
        else if (sample_tick)
            sample_cnt_r <= sample_cnt_r + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sum_r <= '0;
        else if (state_r == adc_rate_pkg::ST_CONVERT && sample_tick)
            sum_r <= sum_in;
    end

    // Result is the final window scaled to full scale; earlier windows settle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            result_r <= '0;
        else if (state_r == adc_rate_pkg::ST_CONVERT && conv_end)
            result_r <= adc_rate_pkg::RESULT_W'(sum_in)
                        << adc_rate_pkg::scale_shift(act_code_r);
    end

    assign result = result_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            conv_count_r <= '0;
        else if (state_r == adc_rate_pkg::ST_CONVERT && conv_end)
            conv_count_r <= conv_count_r + 1'b1;
    end

    // ========================================
    // Conversion and sleep sequence
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            adc_rate_pkg::ST_CONVERT:
            begin
                if (conv_end)
                    state_nxt = adc_rate_pkg::ST_SLEEP;
            end
            adc_rate_pkg::ST_SLEEP:
            begin
                // Chip select high or no clocking keeps the part asleep
                if (!cs_n && shift_active)
                    state_nxt = adc_rate_pkg::ST_READOUT;
            end
            adc_rate_pkg::ST_READOUT:
            begin
                // Finishing or aborting readout starts the next conversion
                if (readout_done || cs_n)
                    state_nxt = adc_rate_pkg::ST_CONVERT;
            end
            default:
            begin
                state_nxt = adc_rate_pkg::ST_CONVERT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= adc_rate_pkg::ST_CONVERT;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_r <= 1'b1;
        else
            busy_r <= state_nxt == adc_rate_pkg::ST_CONVERT;
    end

    // Busy stays low through readout until the next conversion starts
    assign busy = busy_r;
    assign conv_done_n = busy_r;

    // ========================================
    // Avalon-MM slave
    // Every access takes one wait state; the answer is on the second edge
    assign waitrequest = (read | write) & ~ack_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_r <= 1'b0;
        else
            ack_r <= (read | write) & ~ack_r;
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (address)
            adc_rate_pkg::REG_CTRL:
                rd_mux = 32'(ctrl_code_r);
            adc_rate_pkg::REG_STATUS:
                rd_mux = {26'h000_0000, serial_config_in, busy_r,
                          ext_active, act_code_r == adc_rate_pkg::CODE_MAX,
                          state_r};
            adc_rate_pkg::REG_RESULT:
                rd_mux = 32'(result_r);
            adc_rate_pkg::REG_RATIO:
                rd_mux = 32'(oversample_ratio);
            adc_rate_pkg::REG_COUNT:
                rd_mux = 32'(conv_count_r);
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            readdata_r <= 32'h0000_0000;
        else if (read && !ack_r)
            readdata_r <= rd_mux;
    end

    assign readdata = readdata_r;

    // Out-of-range steps clamp to the largest ratio
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_code_r <= adc_rate_pkg::CTRL_RESET;
        else if (write && ack_r && address == adc_rate_pkg::REG_CTRL)
        begin
            if (writedata[adc_rate_pkg::CODE_W-1:0] > adc_rate_pkg::CODE_MAX)
                ctrl_code_r <= adc_rate_pkg::CODE_MAX;
            else
                ctrl_code_r <= writedata[adc_rate_pkg::CODE_W-1:0];
        end
    end

endmodule : adc_rate_sleep_ctrl
`default_nettype wire

// ==== verification/adc_rate_sleep_ctrl_assertions.sv ====
// Port-level checker for the rate and sleep controller
`timescale 1ns/1ps
`default_nettype none
module adc_rate_checker #(
    parameter int EXT_TIMEOUT_CYC = 800
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    // Pins
    input wire logic osc_source_pin,
    input wire logic cs_n,
    input wire logic readout_done,
    // Status
    input wire logic busy,
    input wire logic conv_done_n,
    input wire logic [adc_rate_pkg::RESULT_W-1:0] result,
    input wire logic ext_clock_active
);
    // ========================================
    // Helper counters
    logic [23:0] busy_cnt_r;
    logic [11:0] quiet_cnt_r;
    logic pin_d_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_cnt_r <= '0;
            quiet_cnt_r <= '0;
            pin_d_r <= 1'b0;
        end
        else
        begin
            busy_cnt_r <= busy ? busy_cnt_r + 24'h1 : 24'h0;
            pin_d_r <= osc_source_pin;
            if (osc_source_pin != pin_d_r)
                quiet_cnt_r <= '0;
            else if (quiet_cnt_r != 12'hFFF)
                quiet_cnt_r <= quiet_cnt_r + 12'h1;
        end
    end

    // ========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_done_busy_equal: assert property (conv_done_n == busy)
        else $error("done flag differs from busy");
    // Chip select already high a cycle earlier: a readout abort is a legal wake
    a_sleep_holds: assert property (!busy && cs_n && $past(cs_n) && !readout_done
        |=> !busy)
        else $error("woke while chip select high");
    a_wake_cause: assert property ($rose(busy) |-> $past(readout_done) || $past(cs_n))
        else $error("conversion restarted without readout end");
    a_conv_min_len: assert property ($fell(busy) |-> busy_cnt_r >= 24'h001388)
        else $error("conversion shorter than minimum ratio allows");
    a_result_steady: assert property (!$fell(busy) |-> $stable(result))
        else $error("result changed outside conversion end");
    a_result_scale: assert property (result <= 24'h800000)
        else $error("result above full scale");
    a_int_fallback: assert property (32'(quiet_cnt_r) > EXT_TIMEOUT_CYC + 4 |-> !ext_clock_active)
        else $error("external clock flagged on a steady pin");
    a_ext_edges: assert property ($rose(ext_clock_active) |-> quiet_cnt_r < 12'h008)
        else $error("external clock flagged without pin edges");
    a_bus_answer: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not in second cycle");
endmodule : adc_rate_checker

bind adc_rate_sleep_ctrl adc_rate_checker #(.EXT_TIMEOUT_CYC(EXT_TIMEOUT_CYC)) checker_inst (
    .clk(clk), .rst_n(rst_n), .read(read), .write(write), .waitrequest(waitrequest),
    .osc_source_pin(osc_source_pin), .cs_n(cs_n), .readout_done(readout_done),
    .busy(busy), .conv_done_n(conv_done_n), .result(result),
    .ext_clock_active(ext_clock_active));
`default_nettype wire

// ==== verification/readout_partner.sv ====
// Controller model: chip select, readout and external clock on the select pin
`timescale 1ns/1ps
`default_nettype none
module readout_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Commands
    input wire logic ext_en,
    input wire logic start_read,
    input wire logic abort_read,
    // Pins
    output logic cs_n,
    output logic shift_active,
    output logic readout_done,
    output logic osc_source_pin
);
    logic [5:0] cnt_r;
    logic active_r;
    logic abort_r;
    // Pin grounded unless the clock is enabled; fastest legal toggle rate
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            osc_source_pin <= 1'b0;
        else
            osc_source_pin <= ext_en ? ~osc_source_pin : 1'b0;
    // Chip select idles high so the device sleeps between reads
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_n <= 1'b1;
            shift_active <= 1'b0;
            readout_done <= 1'b0;
            cnt_r <= '0;
            active_r <= 1'b0;
            abort_r <= 1'b0;
        end
        else
        begin
            readout_done <= 1'b0;
            if (!active_r && (start_read || abort_read))
            begin
                active_r <= 1'b1;
                abort_r <= abort_read;
                cnt_r <= '0;
                cs_n <= 1'b0;
            end
            else if (active_r)
            begin
                cnt_r <= cnt_r + 6'h1;
                if (cnt_r == 6'h01)
                    shift_active <= 1'b1;
                // Abort releases chip select early without a done pulse
                if ((abort_r && cnt_r == 6'h05) || cnt_r == 6'h21)
                begin
                    shift_active <= 1'b0;
                    readout_done <= !abort_r;
                    cs_n <= 1'b1;
                    active_r <= 1'b0;
                end
            end
        end
    end
endmodule : readout_partner
`default_nettype wire

// ==== verification/test_adc_rate_sleep_ctrl.sv ====
// Self-checking bench for the rate and sleep controller
`timescale 1ns/1ps
`default_nettype none
module test_adc_rate_sleep_ctrl;
    logic clk, rst_n, read, write, waitrequest, serial_config_in, mod_bit, cs_n;
    logic shift_active, readout_done, osc_source_pin, busy, conv_done_n, ext_clock_active;
    logic ext_en, start_read, abort_read;
    logic [adc_rate_pkg::ADDR_W-1:0] address;
    logic [31:0] writedata, readdata;
    logic [adc_rate_pkg::RESULT_W-1:0] result;
    int mismatches, total_checks, cyc, t0, n;

    adc_rate_sleep_ctrl #(.EXT_TIMEOUT_CYC(20)) adc_rate_sleep_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .osc_source_pin(osc_source_pin), .serial_config_in(serial_config_in), .cs_n(cs_n),
        .mod_bit(mod_bit), .shift_active(shift_active), .readout_done(readout_done),
        .busy(busy), .conv_done_n(conv_done_n), .result(result),
        .ext_clock_active(ext_clock_active));
    readout_partner readout_partner_inst (
        .clk(clk), .rst_n(rst_n), .ext_en(ext_en), .start_read(start_read),
        .abort_read(abort_read), .cs_n(cs_n), .shift_active(shift_active),
        .readout_done(readout_done), .osc_source_pin(osc_source_pin));

    always #12.5 clk = ~clk;

    // ========================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        address <= a;
        writedata <= d;
        if (wr)
            write <= 1'b1;
        else
            read <= 1'b1;
        // Hold the request until the edge that samples waitrequest low;
        // only the bench ceiling ends a wait that never gets an answer
        do
        begin
            @(posedge clk);
            k++;
        end
        while (waitrequest !== 1'b0);
        if (!wr)
            chk(readdata, d, "read data");
        chk(k, 2, "bus answer latency");
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wait_busy(input logic lvl, input int lim);
        n = 0;
        while (busy !== lvl && n < lim) begin @(posedge clk); n++; end
    endtask : wait_busy

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // Ceiling well above the two conversions plus bus traffic
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin mismatches++; summarize(); end
    end

    // ========================================
    // Tests
    initial
    begin
        {clk, rst_n, read, write, serial_config_in, ext_en, start_read, abort_read} = '0;
        {address, writedata, mismatches, total_checks, cyc} = '0;
        mod_bit = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t0 = cyc;
        chk({31'h0, busy & conv_done_n}, 1, "busy after reset");
        bus(0, adc_rate_pkg::REG_CTRL, 0);
        bus(0, adc_rate_pkg::REG_RATIO, 64);
        wait_busy(0, 20000);
        chk({31'h0, (cyc - t0) inside {[11340:11420]}}, 1, "internal conversion time");
        chk(32'(result), 32'h800000, "full scale result");
        chk({31'h0, conv_done_n}, 0, "done flag low asleep");
        bus(0, adc_rate_pkg::REG_STATUS, 1);
        $display("test internal conversion done");
        serial_config_in <= 1'b1;
        @(posedge clk);
        bus(0, adc_rate_pkg::REG_RATIO, 32768);
        bus(0, adc_rate_pkg::REG_STATUS, 32'h25);
        serial_config_in <= 1'b0;
        bus(1, adc_rate_pkg::REG_CTRL, 32'hF);
        bus(0, adc_rate_pkg::REG_CTRL, 9);
        bus(1, adc_rate_pkg::REG_CTRL, 1);
        bus(0, adc_rate_pkg::REG_RATIO, 128);
        bus(0, 5'h14, 0);
        $display("test ratio settings done");
        ext_en <= 1'b1;
        repeat (200) @(posedge clk);
        chk({31'h0, ext_clock_active}, 1, "external clock seen");
        chk({31'h0, busy}, 0, "still asleep");
        start_read <= 1'b1;
        @(posedge clk);
        start_read <= 1'b0;
        wait_busy(1, 100);
        t0 = cyc;
        wait_busy(0, 20000);
        chk({31'h0, (cyc - t0) inside {[10200:10280]}}, 1, "external conversion time");
        chk(32'(result), 32'h800000, "full scale result");
        bus(0, adc_rate_pkg::REG_COUNT, 2);
        $display("test external clock done");
        abort_read <= 1'b1;
        @(posedge clk);
        abort_read <= 1'b0;
        wait_busy(1, 20);
        chk({31'h0, busy}, 1, "abort restarts conversion");
        ext_en <= 1'b0;
        repeat (100) @(posedge clk);
        chk({31'h0, ext_clock_active}, 0, "back to internal oscillator");
        $display("test abort and fallback done");
        summarize();
    end
endmodule : test_adc_rate_sleep_ctrl
`default_nettype wire
